/* design/acs_map.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
//
// Notes on behaviour
// - Each nibble drives only while its enable low
// - Multiplexer selects a channel only when enabled
// - Address register changes only while permit high
// - Four binary address bits; differential uses three
// - Address register shown on address outputs
// - Settling delay pulse lasts six microseconds
// - Delay output wired to falling-edge trigger
// - Mode input high counts, low loads
// - Clear permit low plus strobe fall zeroes
// - Strobe fall steps scan or starts conversion
// - Converter clock pulses low about 100 ns
// - Rising edge on positive trigger starts conversion
// - Falling edge on negative trigger starts conversion
// - End-of-conversion high while converting, then low
// - True and inverted MSB both provided
// - Short-cycle input ends conversion early
// - Free-running scan follows positive trigger level
// - Sequential strobe fall increments address by one
// - Random strobe fall loads address inputs
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ACS_CTRL_OFF      8'h00
`define ACS_STATUS_OFF    8'h04
`define ACS_RESULT_OFF    8'h08

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define ACS_CTRL_DIFF_BIT 0
`define ACS_CTRL_FREE_BIT 1
`define ACS_CTRL_RESET    2'h0
`define ACS_ST_EOC_BIT    4
`define ACS_ST_DLY_BIT    5
`define ACS_ST_MUX_BIT    6
`define ACS_RESULT_TRIAL  12'h800

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ACS_CLK_NS        40
`define ACS_DELAY_NS      6000
`define ACS_PULSE_NS      100
`define ACS_DELAY_CYC     ((`ACS_DELAY_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_PULSE_CYC     ((`ACS_PULSE_NS / `ACS_CLK_NS) < 1 ? 1 : \
                           (`ACS_PULSE_NS / `ACS_CLK_NS))
`define ACS_BIT_CYC       8

`endif

/* design/acs_pkg.sv */
// Types shared by the acquisition channel sequencer
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_CONV = 2'b01
  } acs_state_e;

  typedef logic [3:0] acs_addr_t;

endpackage

/* design/acs_seq.sv */
// Acquisition channel sequencer: address, delay, conversion, APB
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_seq
  import acs_pkg::*;
#(
  parameter int DELAY_CYC = `ACS_DELAY_CYC,
  parameter int PULSE_CYC = `ACS_PULSE_CYC,
  parameter int BIT_CYC   = `ACS_BIT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins from the host
  input  wire logic        strobe,
  input  wire logic        trig_pos,
  input  wire logic        trig_neg,
  input  wire logic        mux_en,
  input  wire logic        count_en,
  input  wire logic        load_en,
  input  wire logic        clear_en_n,
  input  wire logic [3:0]  addr_in,
  input  wire logic [2:0]  oe_n,
  input  wire logic        short_cycle,
  input  wire logic        cmp_in,
  input  wire logic        msb_in,
  // Multiplexer and address
  output acs_addr_t        mux_sel,
  output logic             mux_on,
  output acs_addr_t        addr_out,
  // Converter status and timing
  output logic             delay_out,
  output logic             eoc,
  output logic             conv_clk_n,
  output logic             serial_out,
  output logic             msb_out,
  output logic             msb_out_n,
  // Three-state result nibbles
  output logic [11:0]      data_out,
  output logic [2:0]       data_oe
);

  // ------------------------------------------------------------
  // Pin synchronisers and glitch filter
  // ------------------------------------------------------------
  localparam int SW = 17;

  logic [SW-1:0] raw;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] flt;
  logic [SW-1:0] agree;
  logic [SW-1:0] upd;

  assign raw = {addr_in, msb_in, cmp_in, short_cycle, oe_n, clear_en_n,
                load_en, count_en, mux_en, trig_neg, trig_pos, strobe};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A level counts only once two stages agree
  assign agree = ~(s2 ^ s3);
  assign upd   = agree & (s3 ^ flt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt <= '0;
    end else begin
      flt <= (flt & ~agree) | (s3 & agree);
    end
  end

  logic      strobe_fall;
  logic      tpos_rise;
  logic      tneg_fall;
  logic      tpos_f;
  logic      mux_en_f;
  logic      cnt_en_f;
  logic      load_en_f;
  logic      clr_n_f;
  logic [2:0] oe_n_f;
  logic      short_f;
  logic      cmp_f;
  logic      msb_in_f;
  acs_addr_t addr_in_f;

  assign strobe_fall = upd[0] & flt[0];
  assign tpos_rise   = upd[1] & s3[1];
  assign tneg_fall   = upd[2] & flt[2];
  assign tpos_f      = flt[1];
  assign mux_en_f    = flt[3];
  assign cnt_en_f    = flt[4];
  assign load_en_f   = flt[5];
  assign clr_n_f     = flt[6];
  assign oe_n_f      = flt[9:7];
  assign short_f     = flt[10];
  assign cmp_f       = flt[11];
  assign msb_in_f    = flt[12];
  assign addr_in_f   = flt[16:13];

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [1:0] ctrl;
  logic       diff_mode;
  logic       free_run;

  assign diff_mode = ctrl[`ACS_CTRL_DIFF_BIT];
  assign free_run  = ctrl[`ACS_CTRL_FREE_BIT];

  // Highest channel of the active variant
  function automatic acs_addr_t acs_top(input logic diff);
    acs_top = diff ? 4'h7 : 4'hf;
  endfunction

  // ------------------------------------------------------------
  // Channel address register
  // ------------------------------------------------------------
  acs_addr_t addr;

  assign addr_out = addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= 4'h0;
    end else if (strobe_fall && cnt_en_f) begin
      if (!clr_n_f) begin
        addr <= 4'h0;
      end else if (load_en_f) begin
        if (addr >= acs_top(diff_mode)) begin
          addr <= 4'h0;
        end else begin
          addr <= addr + 4'h1;
        end
      end else begin
        addr <= addr_in_f & acs_top(diff_mode);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_sel <= 4'h0;
      mux_on  <= 1'b0;
    end else begin
      mux_sel <= addr;
      mux_on  <= mux_en_f;
    end
  end

  // ------------------------------------------------------------
  // Settling delay pulse
  // ------------------------------------------------------------
  localparam int DW = $clog2(DELAY_CYC + 1);
  localparam logic [DW-1:0] DLY_LOAD = DW'(DELAY_CYC);

  logic [DW-1:0] dly_cnt;

  // Restarted by every strobe fall, even one during a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt   <= '0;
      delay_out <= 1'b0;
    end else if (strobe_fall) begin
      dly_cnt   <= DLY_LOAD;
      delay_out <= 1'b1;
    end else if (dly_cnt != '0) begin
      dly_cnt <= dly_cnt - DW'(1);
      if (dly_cnt == DW'(1)) begin
        delay_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Successive approximation conversion
  // ------------------------------------------------------------
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] LOW_LAST = CW'(PULSE_CYC - 1);

  acs_state_e    state;
  logic [3:0]    bit_idx;
  logic [CW-1:0] cyc;
  logic [11:0]   result;
  logic          start;

  // In free-running mode a low positive trigger stops the scan
  assign start = tpos_rise ||
                 (tneg_fall && (!free_run || tpos_f));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ACS_IDLE;
      bit_idx    <= 4'h0;
      cyc        <= '0;
      result     <= 12'h000;
      eoc        <= 1'b0;
      conv_clk_n <= 1'b1;
      serial_out <= 1'b0;
    end else begin
      case (state)
        ACS_IDLE: begin
          conv_clk_n <= 1'b1;
          if (start) begin
            state      <= ACS_CONV;
            bit_idx    <= 4'hb;
            cyc        <= '0;
            result     <= `ACS_RESULT_TRIAL;
            eoc        <= 1'b1;
            conv_clk_n <= 1'b0;
          end
        end
        ACS_CONV: begin
          cyc <= cyc + CW'(1);
          if (cyc == LOW_LAST) begin
            conv_clk_n <= 1'b1;
          end
          if (cyc == CYC_LAST) begin
            // Short cycle: the tapped bit is dropped, not kept
            if (short_f) begin
              result[bit_idx] <= 1'b0;
              serial_out      <= 1'b0;
              state           <= ACS_IDLE;
              eoc             <= 1'b0;
            end else begin
              result[bit_idx] <= cmp_f;
              serial_out      <= cmp_f;
              if (bit_idx == 4'h0) begin
                state <= ACS_IDLE;
                eoc   <= 1'b0;
              end else begin
                bit_idx              <= bit_idx - 4'h1;
                result[bit_idx - 1]  <= 1'b1;
                cyc                  <= '0;
                conv_clk_n           <= 1'b0;
              end
            end
          end
        end
        default: begin
          state <= ACS_IDLE;
          eoc   <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msb_out   <= 1'b0;
      msb_out_n <= 1'b1;
      data_out  <= 12'h000;
      data_oe   <= 3'h0;
    end else begin
      msb_out   <= result[11];
      msb_out_n <= ~result[11];
      data_out  <= {msb_in_f, result[10:0]};
      data_oe   <= ~oe_n_f;
    end
  end

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  logic setup;
  logic access;
  logic hit;

  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign hit    = (paddr == `ACS_CTRL_OFF) ||
                  (paddr == `ACS_STATUS_OFF) ||
                  (paddr == `ACS_RESULT_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ACS_CTRL_RESET;
    end else if (access && pwrite && paddr == `ACS_CTRL_OFF) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        case (paddr)
          `ACS_CTRL_OFF: prdata <= {30'h0, ctrl};
          `ACS_STATUS_OFF: prdata <= {25'h0, mux_on, delay_out, eoc, addr};
          `ACS_RESULT_OFF: prdata <= {20'h0, result};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [DW:0] dly_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_seen <= '0;
    end else if (strobe_fall) begin
      dly_seen <= (DW+1)'(1);
    end else if (delay_out) begin
      dly_seen <= dly_seen + (DW+1)'(1);
    end
  end

  chk_nibble_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(oe_n_f) |=> (data_oe == ~$past(oe_n_f)))
    else $error("nibble enable does not follow its pin");

  chk_mux_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mux_en_f ##1 !mux_en_f |-> !mux_on)
    else $error("multiplexer on while disabled");

  chk_addr_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cnt_en_f |=> $stable(addr))
    else $error("address changed without permit");

  chk_addr_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_fall && cnt_en_f && clr_n_f && load_en_f &&
    addr == acs_top(diff_mode) |=> addr == 4'h0)
    else $error("counter did not wrap");

  chk_addr_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_fall && cnt_en_f && clr_n_f && load_en_f &&
    addr < acs_top(diff_mode) |=> addr == $past(addr) + 4'h1)
    else $error("counter did not step by one");

  chk_addr_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_fall && cnt_en_f && clr_n_f && !load_en_f
    |=> addr == ($past(addr_in_f) & acs_top(diff_mode)))
    else $error("address inputs not loaded");

  chk_addr_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_fall && cnt_en_f && !clr_n_f |=> addr == 4'h0)
    else $error("clear did not zero the address");

  chk_delay_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(delay_out) |-> $past(dly_seen) == DELAY_CYC)
    else $error("settling pulse has wrong length");

  chk_delay_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_fall |=> delay_out)
    else $error("settling pulse did not start");

  chk_conv_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && state == ACS_IDLE |=> eoc ##[1:200] !eoc)
    else $error("conversion status wrong");

  chk_clk_width: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(conv_clk_n) |-> !conv_clk_n[*2] ##1 conv_clk_n)
    else $error("converter clock pulse width wrong");

  chk_msb_pair: assert property (
    @(posedge pclk) disable iff (!presetn)
    msb_out != msb_out_n)
    else $error("MSB outputs not complementary");

  chk_short_end: assert property (
    @(posedge pclk) disable iff (!presetn)
    state == ACS_CONV && cyc == CYC_LAST && short_f |=> !eoc)
    else $error("short cycle did not end conversion");

endmodule
`default_nettype wire

/* sim/acquisition_channel_sequencer_bench.sv */
// Self-checking bench of the acquisition channel sequencer
`timescale 1ns/1ps
`default_nettype none
module acquisition_channel_sequencer_bench;
  import acs_pkg::*;
  localparam int          DLY = 10;
  localparam logic [11:0] TGT = 12'ha54;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, strobe = 1, trig_pos = 0, trig_neg, mux_en = 1;
  logic count_en = 1, load_en = 0, clear_en_n = 1, cmp_in, msb_in;
  logic sc_on = 0, tc = 0, mux_on, delay_out, eoc, conv_clk_n, e;
  logic serial_out, msb_out, msb_out_n, short_cycle;
  logic [3:0]  addr_in = 4'h0;
  logic [2:0]  oe_n = 3'h0, data_oe;
  logic [11:0] data_out;
  acs_addr_t   mux_sel, addr_out;
  int          errors = 0, checks = 0, hi;

  assign short_cycle = sc_on & data_out[3];
  assign msb_in = tc ? msb_out_n : msb_out;
  always #20 pclk = ~pclk;

  acs_seq #(.DELAY_CYC(DLY)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe(strobe), .trig_pos(trig_pos), .trig_neg(trig_neg),
    .mux_en(mux_en), .count_en(count_en), .load_en(load_en),
    .clear_en_n(clear_en_n), .addr_in(addr_in), .oe_n(oe_n),
    .short_cycle(short_cycle), .cmp_in(cmp_in), .msb_in(msb_in),
    .mux_sel(mux_sel), .mux_on(mux_on), .addr_out(addr_out),
    .delay_out(delay_out), .eoc(eoc), .conv_clk_n(conv_clk_n),
    .serial_out(serial_out), .msb_out(msb_out), .msb_out_n(msb_out_n),
    .data_out(data_out), .data_oe(data_oe));

  acs_host_model #(.TARGET(TGT)) u_host (.pclk(pclk),
    .delay_out(delay_out), .eoc(eoc), .conv_clk_n(conv_clk_n),
    .trig_neg(trig_neg), .cmp_in(cmp_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  // Called just after a rising edge; read data taken with pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(negedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never reassigns psel at once
    @(posedge pclk);
  endtask

  // Strobe fall, counting settling pulse cycles meanwhile
  task automatic strobe_fall;
    @(posedge pclk);
    strobe <= 1'b0;
    hi = 0;
    repeat (30) begin
      @(negedge pclk);
      if (delay_out === 1'b1) hi++;
    end
    @(posedge pclk);
    strobe <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic convert(input logic [11:0] x, input int cyc, input int n);
    int ec, f, lo;
    logic q;
    ec = 0;
    f = 0;
    lo = 0;
    q = 1'b1;
    repeat (300) begin
      @(negedge pclk);
      if (eoc === 1'b0) break;
    end
    @(posedge pclk);
    trig_pos <= 1'b1;
    repeat (160) begin
      @(negedge pclk);
      if (eoc === 1'b1) ec++;
      if (conv_clk_n === 1'b0) lo++;
      if (q === 1'b1 && conv_clk_n === 1'b0) f++;
      q = conv_clk_n;
    end
    @(posedge pclk);
    trig_pos <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("eoc cycles", cyc, ec);
    chk("clock pulses", n, f);
    chk("clock low", 2 * n, lo);
    chk("data", {tc ^ x[11], x[10:0]}, data_out);
    chk("msb pair", {x[11], ~x[11]}, {msb_out, msb_out_n});
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, r);
    apb(1'b1, 8'h10, 32'h3);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, r);
    $display("test registers done");
    addr_in <= 4'h9;
    strobe_fall;
    chk("random load", 32'h9, addr_out);
    chk("delay length", DLY, hi);
    chk("delay trigger", 32'h1, {31'h0, eoc});
    chk("mux select", 32'h9, mux_sel);
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h59, r & 32'h7f);
    mux_en <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("mux off", 32'h0, {31'h0, mux_on});
    mux_en <= 1'b1;
    $display("test random done");
    addr_in <= 4'he;
    strobe_fall;
    load_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      strobe_fall;
      chk("count", 4'(4'hf + 4'(i)), addr_out);
    end
    clear_en_n <= 1'b0;
    strobe_fall;
    chk("clear", 32'h0, addr_out);
    clear_en_n <= 1'b1;
    count_en <= 1'b0;
    strobe_fall;
    chk("frozen", 32'h0, addr_out);
    count_en <= 1'b1;
    $display("test sequential done");
    @(posedge pclk);
    apb(1'b1, 8'h00, 32'h1);
    load_en <= 1'b0;
    addr_in <= 4'hf;
    strobe_fall;
    chk("diff load", 32'h7, addr_out);
    load_en <= 1'b1;
    strobe_fall;
    chk("diff wrap", 32'h0, addr_out);
    @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0);
    $display("test differential done");
    convert(TGT, 96, 12);
    chk("serial last", TGT[0], serial_out);
    tc <= 1'b1;
    convert(TGT, 96, 12);
    tc <= 1'b0;
    sc_on <= 1'b1;
    convert(TGT & 12'hff0, 72, 9);
    sc_on <= 1'b0;
    $display("test conversion done");
    // Free-running with the positive trigger low: no conversion
    apb(1'b1, 8'h00, 32'h2);
    strobe_fall;
    chk("free stop", 32'h0, {31'h0, eoc});
    apb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      oe_n <= ~(3'h1 << i);
      repeat (8) @(posedge pclk);
      chk("nibble enable", 3'(3'h1 << i), data_oe);
    end
    $display("test enables done");
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire

/* sim/acs_host_model.sv */
// Behavioural host side: trigger wiring and comparator answers
`timescale 1ns/1ps
`default_nettype none
module acs_host_model #(
  parameter logic [11:0] TARGET = 12'ha54
) (
  // Clock
  input  wire logic pclk,
  // From the sequencer
  input  wire logic delay_out,
  input  wire logic eoc,
  input  wire logic conv_clk_n,
  // To the sequencer
  output logic      trig_neg,
  output logic      cmp_in
);
  logic [3:0] idx   = 4'hb;
  logic       clk_q = 1'b1;
  logic       cmp_q = 1'b0;
  // End of settling pulse fires the falling-edge trigger
  assign trig_neg = delay_out;
  assign cmp_in   = cmp_q;
  // One target bit per converter clock, MSB first
  always @(posedge pclk) begin
    clk_q <= conv_clk_n;
    if (eoc !== 1'b1) begin
      idx   <= 4'hb;
      cmp_q <= ~cmp_q; // Idle line means nothing, so keep it moving
    end else if (clk_q && !conv_clk_n) begin
      cmp_q <= TARGET[idx];
      idx   <= idx - 4'h1;
    end
  end
endmodule
`default_nettype wire
